// ---- design/drsr_sched.sv ----
// Request scheduler that spaces row and column commands to a multi-bank DRAM
// Behaviour
// [R01] Row opens, other banks: open-to-open gap
// [R02] Row opens, same bank: row cycle, close between
// [R03] Read then close: read-to-close gap
// [R04] Close then open: close-to-open gap
// [R05] Read then open: close inserted, summed gap
// [R06] Write then close: write-to-close gap
// [R07] Write then open: close inserted, summed gap
// [R08] Open then read: open-to-read gap
// [R09] Read after read: column cycle, any bank
// [R10] Write then read: write-to-read turnaround, any bank
// [R11] Close then read: open inserted, summed gap
// [R12] Open then write: open-to-write gap
// [R13] Read then write: read-to-write turnaround, any bank
// [R14] Write after write: column cycle, any bank
// [R15] Close then write: open inserted, summed gap
// [R16] Open then close: minimum row-open gap
// [R17] Closes, other banks: close-to-close gap
// [R18] Closes, same bank: row cycle, open between
// [R19] Unlisted pairs may go back to back
// [R20] Gaps count from effective, delayed position
// [R21] Per-bank record blocks until gaps elapse
module drsr_sched
	import drsr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// User request
	input wire logic reqValid,
	output logic reqReady,
	input wire drsr_req_s req,
	// Completion
	output logic doneStb,
	output logic busy,
	// Request bus
	output drsr_pkt_s requestBus,
	// Bank state
	output logic [BANKS-1:0] bankOpen
);

	// ************************************************************
	// State machine
	// ************************************************************
	// Gray codes along idle, decide, close, open, column
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DECIDE = 3'b001,
		ST_CLOSE = 3'b011,
		ST_OPEN = 3'b010,
		ST_COLUMN = 3'b110
	} drsr_state_e;

	drsr_state_e state_r;         // Current state
	drsr_state_e state_nxt;       // Next state
	drsr_req_s req_r;             // Request being served
	drsr_pkt_s pkt_r;             // Packet on the request bus
	logic done_r;                 // Request finished pulse

	// Last bank of each row command, for the other-bank gaps
	logic [BANK_W-1:0] lastOpenBank_r;
	logic [BANK_W-1:0] lastCloseBank_r;
	logic openSeen_r;             // Any row open issued yet
	logic closeSeen_r;            // Any row close issued yet

	// Row tracking
	logic [BANKS-1:0][ROW_W-1:0] openRow;   // Open row per bank
	logic curOpen;                          // Target bank open
	logic curHit;                           // Open row matches

	// Timers
	logic [BANKS*BANK_TMR-1:0] bankLoad;    // Per-bank load strobes
	drsr_cnt_t [BANKS*BANK_TMR-1:0] bankVal;// Per-bank load values
	drsr_cnt_t [BANKS*BANK_TMR-1:0] bankRem;// Per-bank remaining
	logic [GLOB_TMR-1:0] globLoad;          // Shared load strobes
	drsr_cnt_t [GLOB_TMR-1:0] globVal;      // Shared load values
	drsr_cnt_t [GLOB_TMR-1:0] globRem;      // Shared remaining

	// Issue decision
	drsr_cmd_e issueCmd;          // Command wanted this cycle
	logic issueOk;                // All gaps have elapsed
	logic issue;                  // Command goes out now
	logic [DEL_W-1:0] issueDel;   // Delay field of that command
	drsr_cnt_t delExt;            // Delay widened to counter width
	drsr_cnt_t bRem;              // Remaining in the selected slot

	// Per-command gap values, delay folded in
	drsr_cnt_t vRc;
	drsr_cnt_t vRp;
	drsr_cnt_t vRdpRp;
	drsr_cnt_t vWdpRp;
	drsr_cnt_t vRdp;
	drsr_cnt_t vWdp;
	drsr_cnt_t vRas;
	drsr_cnt_t vRcdr;
	drsr_cnt_t vRcdw;
	drsr_cnt_t vRpRcdr;
	drsr_cnt_t vRpRcdw;
	drsr_cnt_t vRr;
	drsr_cnt_t vPp;
	drsr_cnt_t vCc;
	drsr_cnt_t vWr;
	drsr_cnt_t vRw;

	// ************************************************************
	// Submodules
	// ************************************************************
	// Open row record per bank
	drsr_row_track uTrack (
		.clk(clk),
		.rst_n(rst_n),
		.openEv(issue && (issueCmd == CMD_ROW_OPEN)),
		.closeEv(issue && (issueCmd == CMD_ROW_CLOSE)),
		.evBank(req_r.bank),
		.evRow(req_r.row),
		.bankOpen(bankOpen),
		.openRow(openRow)
	);

	// Per-bank gap counters
	drsr_gap_timer #(
		.N(BANKS*BANK_TMR)
	) uBankTmr (
		.clk(clk),
		.rst_n(rst_n),
		.loadEn(bankLoad),
		.loadVal(bankVal),
		.remain(bankRem)
	);

	// Gaps that span all banks
	drsr_gap_timer #(
		.N(GLOB_TMR)
	) uGlobTmr (
		.clk(clk),
		.rst_n(rst_n),
		.loadEn(globLoad),
		.loadVal(globVal),
		.remain(globRem)
	);

	// ************************************************************
	// Gap values
	// ************************************************************
	// Counter holds interval + delay - 1 one cycle after issue
	assign delExt = CNT_W'(issueDel);
	assign vRc = CNT_W'(RC_CYC - 1) + delExt;                    // [R02] [R18] [R20]
	assign vRp = CNT_W'(RP_CYC - 1) + delExt;                    // [R04]
	assign vRdpRp = CNT_W'(RDP_CYC + RP_CYC - 1) + delExt;       // [R05]
	assign vWdpRp = CNT_W'(WDP_CYC + RP_CYC - 1) + delExt;       // [R07]
	assign vRdp = CNT_W'(RDP_CYC - 1) + delExt;                  // [R03]
	assign vWdp = CNT_W'(WDP_CYC - 1) + delExt;                  // [R06]
	assign vRas = CNT_W'(RAS_CYC - 1) + delExt;                  // [R16]
	assign vRcdr = CNT_W'(RCDR_CYC - 1) + delExt;                // [R08]
	assign vRcdw = CNT_W'(RCDW_CYC - 1) + delExt;                // [R12]
	assign vRpRcdr = CNT_W'(RP_CYC + RCDR_CYC - 1) + delExt;     // [R11]
	assign vRpRcdw = CNT_W'(RP_CYC + RCDW_CYC - 1) + delExt;     // [R15]
	assign vRr = CNT_W'(RR_CYC - 1) + delExt;                    // [R01]
	assign vPp = CNT_W'(PP_CYC - 1) + delExt;                    // [R17]
	assign vCc = CNT_W'(CC_CYC - 1) + delExt;                    // [R09] [R14]
	assign vWr = CNT_W'(WR_CYC - 1) + delExt;                    // [R10]
	assign vRw = CNT_W'(RW_CYC - 1) + delExt;                    // [R13]

	// ************************************************************
	// Timer loads
	// ************************************************************
	// Load the target bank slots for the command being issued
	always_comb begin
		bankLoad = '0;
		bankVal = '0;
		for (int k = 0; k < BANK_TMR; k++) begin
			bankLoad[int'(req_r.bank)*BANK_TMR+k] = issue;    // [R21]
		end
		case (issueCmd)
			CMD_ROW_OPEN: begin
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_ACT] = vRc;
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_RD] = vRcdr;
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_WR] = vRcdw;
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_PRE] = vRas;
			end
			CMD_READ: begin
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_ACT] = vRdpRp;
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_PRE] = vRdp;
			end
			CMD_WRITE: begin
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_ACT] = vWdpRp;
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_PRE] = vWdp;
			end
			CMD_ROW_CLOSE: begin
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_ACT] = vRp;
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_RD] = vRpRcdr;
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_WR] = vRpRcdw;
				bankVal[int'(req_r.bank)*BANK_TMR+SLOT_PRE] = vRc;
			end
			default: begin
				bankLoad = '0;
			end
		endcase
	end

	// Shared slots: 0 opens, 1 closes, 2 next read, 3 next write
	always_comb begin
		globLoad = '0;
		globVal = '0;
		case (issueCmd)
			CMD_ROW_OPEN: begin
				globLoad[0] = issue;
				globVal[0] = vRr;                 // [R01]
			end
			CMD_ROW_CLOSE: begin
				globLoad[1] = issue;
				globVal[1] = vPp;                 // [R17]
			end
			CMD_READ: begin
				globLoad[2] = issue;
				globLoad[3] = issue;
				globVal[2] = vCc;                 // [R09]
				globVal[3] = vRw;                 // [R13]
			end
			CMD_WRITE: begin
				globLoad[2] = issue;
				globLoad[3] = issue;
				globVal[2] = vWr;                 // [R10]
				globVal[3] = vCc;                 // [R14]
			end
			default: begin
				globLoad = '0;
			end
		endcase
	end

	// ************************************************************
	// Issue check
	// ************************************************************
	assign curOpen = bankOpen[req_r.bank];
	assign curHit = curOpen && (openRow[req_r.bank] == req_r.row);

	// Command wanted by the present state
	always_comb begin
		case (state_r)
			ST_CLOSE: issueCmd = CMD_ROW_CLOSE;
			ST_OPEN: issueCmd = CMD_ROW_OPEN;
			ST_COLUMN: issueCmd = (req_r.op == OP_WRITE) ? CMD_WRITE : CMD_READ;
			default: issueCmd = CMD_NOP;
		endcase
	end

	// Only column commands carry the user delay
	assign issueDel = (state_r == ST_COLUMN) ? req_r.delay : '0;

	// Legal once every pending gap is covered by the delay
	always_comb begin
		bRem = '0;
		issueOk = 1'b0;
		case (issueCmd)
			CMD_ROW_OPEN: begin
				bRem = bankRem[int'(req_r.bank)*BANK_TMR+SLOT_ACT];
				issueOk = (bRem <= delExt) &&                   // [R02] [R04] [R05] [R07]
					(!openSeen_r || (lastOpenBank_r == req_r.bank) ||
					(globRem[0] <= delExt));                     // [R01]
			end
			CMD_READ: begin
				bRem = bankRem[int'(req_r.bank)*BANK_TMR+SLOT_RD];
				issueOk = (bRem <= delExt) &&                   // [R08] [R11]
					(globRem[2] <= delExt);                      // [R09] [R10]
			end
			CMD_WRITE: begin
				bRem = bankRem[int'(req_r.bank)*BANK_TMR+SLOT_WR];
				issueOk = (bRem <= delExt) &&                   // [R12] [R15]
					(globRem[3] <= delExt);                      // [R13] [R14]
			end
			CMD_ROW_CLOSE: begin
				bRem = bankRem[int'(req_r.bank)*BANK_TMR+SLOT_PRE];
				issueOk = (bRem <= delExt) &&                   // [R03] [R06] [R16] [R18]
					(!closeSeen_r || (lastCloseBank_r == req_r.bank) ||
					(globRem[1] <= delExt));                     // [R17]
			end
			default: begin
				issueOk = 1'b0;
			end
		endcase
	end

	// Counters at zero let a pair go back to back
	assign issue = issueOk;                       // [R19] [R21]

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (reqValid) begin
					state_nxt = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				if (req_r.op == OP_CLOSE) begin
					state_nxt = curOpen ? ST_CLOSE : ST_IDLE;
				end else if (curHit) begin
					state_nxt = ST_COLUMN;
				end else if (curOpen) begin
					state_nxt = ST_CLOSE;        // [R05] [R07]
				end else begin
					state_nxt = ST_OPEN;         // [R11] [R15]
				end
			end
			ST_CLOSE: begin
				if (issue) begin
					state_nxt = (req_r.op == OP_CLOSE) ? ST_IDLE : ST_OPEN;   // [R02]
				end
			end
			ST_OPEN: begin
				if (issue) begin
					state_nxt = ST_COLUMN;
				end
			end
			ST_COLUMN: begin
				if (issue) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ************************************************************
	// Request capture and completion
	// ************************************************************
	assign reqReady = (state_r == ST_IDLE);

	// Hold the request while it is served
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_r <= '0;
		end else if (reqValid && reqReady) begin
			req_r <= req;
		end
	end

	// Pulse when the request leaves the machine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_r <= 1'b0;
		end else begin
			done_r <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
		end
	end

	assign doneStb = done_r;
	assign busy = (state_r != ST_IDLE);

	// ************************************************************
	// Other-bank history
	// ************************************************************
	// Bank of last row open and row close
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lastOpenBank_r <= '0;
			lastCloseBank_r <= '0;
			openSeen_r <= 1'b0;
			closeSeen_r <= 1'b0;
		end else if (issue && (issueCmd == CMD_ROW_OPEN)) begin
			lastOpenBank_r <= req_r.bank;
			openSeen_r <= 1'b1;
		end else if (issue && (issueCmd == CMD_ROW_CLOSE)) begin
			lastCloseBank_r <= req_r.bank;
			closeSeen_r <= 1'b1;
		end
	end

	// ************************************************************
	// Request bus output
	// ************************************************************
	// One packet per issue, idle otherwise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pkt_r <= PKT_IDLE;
		end else if (issue) begin
			pkt_r.valid <= 1'b1;
			pkt_r.cmd <= issueCmd;
			pkt_r.bank <= req_r.bank;
			pkt_r.row <= req_r.row;
			pkt_r.col <= req_r.col;
			pkt_r.delay <= issueDel;          // [R20]
		end else begin
			pkt_r <= PKT_IDLE;
		end
	end

	assign requestBus = pkt_r;

endmodule

// ---- design/drsr_pkg.sv ----
// Shared constants, types and timing figures for the request spacing scheduler
package drsr_pkg;

	// ************************************************************
	// Geometry
	// ************************************************************
	localparam int BANKS = 8;                 // Banks in the device
	localparam int BANK_W = 3;                // Bank index width
	localparam int ROW_W = 12;                // Row address width
	localparam int COL_W = 6;                 // Column address width
	localparam int DEL_W = 2;                 // Delay field width
	localparam int CNT_W = 7;                 // Spacing counter width
	localparam int BANK_TMR = 4;              // Counters kept per bank
	localparam int GLOB_TMR = 4;              // Counters shared by all banks

	// Per-bank counter slots
	localparam int SLOT_ACT = 0;              // Gate for next row open
	localparam int SLOT_RD = 1;               // Gate for next column read
	localparam int SLOT_WR = 2;               // Gate for next column write
	localparam int SLOT_PRE = 3;              // Gate for next row close

	// ************************************************************
	// Clock and intervals (ns)
	// ************************************************************
	localparam int CLK_NS = 100;              // 10 MHz request clock
	localparam int OPEN_TO_OPEN_OTHER_BANK_NS = 200;
	localparam int ROW_CYCLE_INTERVAL_NS = 900;
	localparam int CLOSE_TO_OPEN_INTERVAL_NS = 300;
	localparam int READ_TO_CLOSE_INTERVAL_NS = 200;
	localparam int WRITE_TO_CLOSE_INTERVAL_NS = 400;
	localparam int MIN_ROW_OPEN_INTERVAL_NS = 600;
	localparam int OPEN_TO_READ_INTERVAL_NS = 300;
	localparam int OPEN_TO_WRITE_INTERVAL_NS = 100;
	localparam int COLUMN_CYCLE_INTERVAL_NS = 200;
	localparam int CLOSE_TO_CLOSE_INTERVAL_NS = 200;
	localparam int WRITE_TO_READ_TURN_NS = 500;
	localparam int READ_TO_WRITE_TURN_NS = 300;

	// Least time to cycles: round up, never below one
	function automatic int toCyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int RR_CYC = toCyc(OPEN_TO_OPEN_OTHER_BANK_NS);
	localparam int RC_CYC = toCyc(ROW_CYCLE_INTERVAL_NS);
	localparam int RP_CYC = toCyc(CLOSE_TO_OPEN_INTERVAL_NS);
	localparam int RDP_CYC = toCyc(READ_TO_CLOSE_INTERVAL_NS);
	localparam int WDP_CYC = toCyc(WRITE_TO_CLOSE_INTERVAL_NS);
	localparam int RAS_CYC = toCyc(MIN_ROW_OPEN_INTERVAL_NS);
	localparam int RCDR_CYC = toCyc(OPEN_TO_READ_INTERVAL_NS);
	localparam int RCDW_CYC = toCyc(OPEN_TO_WRITE_INTERVAL_NS);
	localparam int CC_CYC = toCyc(COLUMN_CYCLE_INTERVAL_NS);
	localparam int PP_CYC = toCyc(CLOSE_TO_CLOSE_INTERVAL_NS);
	localparam int WR_CYC = toCyc(WRITE_TO_READ_TURN_NS);
	localparam int RW_CYC = toCyc(READ_TO_WRITE_TURN_NS);

	// ************************************************************
	// Types
	// ************************************************************
	typedef logic [CNT_W-1:0] drsr_cnt_t;     // Spacing counter value

	// Commands placed on the request bus
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ROW_OPEN = 3'h1,
		CMD_READ = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_ROW_CLOSE = 3'h4
	} drsr_cmd_e;

	// Operations a user may request
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_CLOSE = 2'h2
	} drsr_op_e;

	// User request
	typedef struct packed {
		drsr_op_e op;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [DEL_W-1:0] delay;
	} drsr_req_s;

	// One request bus packet
	typedef struct packed {
		logic valid;
		drsr_cmd_e cmd;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [DEL_W-1:0] delay;
	} drsr_pkt_s;

	localparam drsr_pkt_s PKT_IDLE = '0;      // Bus value after reset

endpackage

// ---- design/drsr_gap_timer.sv ----
// Bank of saturating countdown timers that keep the longest pending gap
module drsr_gap_timer
	import drsr_pkg::*;
#(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Loads
	input wire logic [N-1:0] loadEn,
	input wire drsr_cnt_t [N-1:0] loadVal,
	// Remaining cycles
	output drsr_cnt_t [N-1:0] remain
);

	// ************************************************************
	// Counters
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : gTmr
			drsr_cnt_t cnt_r;    // Cycles still to wait
			drsr_cnt_t dec;      // Value one cycle on

			// Count down to zero and stop
			assign dec = (cnt_r == '0) ? '0 : cnt_r - 1'b1;

			// A load never shortens a longer pending wait
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					cnt_r <= '0;
				end else if (loadEn[i] && (loadVal[i] > dec)) begin
					cnt_r <= loadVal[i];
				end else begin
					cnt_r <= dec;
				end
			end

			assign remain[i] = cnt_r;
		end
	endgenerate

endmodule

// ---- design/drsr_row_track.sv ----
// Per-bank record of which row is held open
module drsr_row_track
	import drsr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Row events
	input wire logic openEv,
	input wire logic closeEv,
	input wire logic [BANK_W-1:0] evBank,
	input wire logic [ROW_W-1:0] evRow,
	// State
	output logic [BANKS-1:0] bankOpen,
	output logic [BANKS-1:0][ROW_W-1:0] openRow
);

	// ************************************************************
	// Entries
	// ************************************************************
	genvar b;
	generate
		for (b = 0; b < BANKS; b++) begin : gBank
			logic open_r;                   // Row held in sense amps
			logic [ROW_W-1:0] row_r;        // Which row

			// Open flag follows open and close commands
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					open_r <= 1'b0;
				end else if (openEv && (evBank == BANK_W'(b))) begin
					open_r <= 1'b1;
				end else if (closeEv && (evBank == BANK_W'(b))) begin
					open_r <= 1'b0;
				end
			end

			// Row address caught on open
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					row_r <= '0;
				end else if (openEv && (evBank == BANK_W'(b))) begin
					row_r <= evRow;
				end
			end

			assign bankOpen[b] = open_r;
			assign openRow[b] = row_r;
		end
	endgenerate

endmodule

// ---- verif/drsr_sched_sva.sv ----
// Port checker for the request spacing scheduler
module drsr_sched_sva
	import drsr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// User side
	input wire logic reqValid,
	input wire logic reqReady,
	input wire drsr_req_s req,
	input wire logic doneStb,
	input wire logic busy,
	// Request bus
	input wire drsr_pkt_s requestBus,
	input wire logic [BANKS-1:0] bankOpen
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Decoded bus events
	// ****
	logic take; // Request accepted
	logic isOpen; // Row open on bus
	logic isClose; // Row close on bus
	logic isRd; // Read on bus
	logic isCol; // Any column command
	assign take = reqValid && reqReady;
	assign isOpen = requestBus.valid && requestBus.cmd == CMD_ROW_OPEN;
	assign isClose = requestBus.valid && requestBus.cmd == CMD_ROW_CLOSE;
	assign isRd = requestBus.valid && requestBus.cmd == CMD_READ;
	assign isCol = isRd || (requestBus.valid && requestBus.cmd == CMD_WRITE);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	chk_ready_idle: assert property (reqReady == !busy)
		else $error("ready and busy disagree");
	chk_take_busy: assert property (take |=> busy)
		else $error("taken request left scheduler idle");
	chk_done_bound: assert property (take |-> ##[2:80] doneStb)
		else $error("request never completed");
	chk_done_once: assert property (doneStb |=> !doneStb)
		else $error("done held longer than a cycle");
	chk_idle_quiet: assert property (!busy && !doneStb |-> !requestBus.valid)
		else $error("packet while idle");
	chk_open_space: assert property (isOpen |=> !isOpen)
		else $error("row opens too close");
	chk_close_space: assert property (isClose |=> !isClose)
		else $error("row closes too close");
	chk_col_space: assert property (
		isCol |=> !isCol || requestBus.delay > $past(requestBus.delay))
		else $error("column commands too close");
	chk_open_read: assert property (isOpen |=> !(isRd &&
		requestBus.bank == $past(requestBus.bank) &&
		int'(requestBus.delay) < RCDR_CYC - 1))
		else $error("read too soon after open");
	chk_open_close: assert property (isOpen |=>
		!(isClose && requestBus.bank == $past(requestBus.bank)))
		else $error("close too soon after open");
endmodule

bind drsr_sched drsr_sched_sva i_drsr_sched_sva (
	.clk(clk),
	.rst_n(rst_n),
	.reqValid(reqValid),
	.reqReady(reqReady),
	.req(req),
	.doneStb(doneStb),
	.busy(busy),
	.requestBus(requestBus),
	.bankOpen(bankOpen)
);

// ---- verif/drsr_dram_model.sv ----
// Device model that audits request bus spacing per bank
module drsr_dram_model
	import drsr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request bus
	input wire drsr_pkt_s requestBus,
	// Spacing faults seen
	output int faults
);
	timeunit 1ns;
	timeprecision 1ns;
	int cyc; // Cycle count
	int tOpen[BANKS]; // Effective time of last open
	int tClose[BANKS]; // Effective time of last close
	int tRd[BANKS]; // Effective time of last read
	int tWr[BANKS]; // Effective time of last write
	logic [BANKS-1:0] rowUp; // Banks holding a row

	// Count a gap that came too soon
	task automatic gap(input int d, input int g);
		if (d < g)
			faults++;
	endtask

	// Audit each packet; pairs with no gap listed pass freely
	always @(posedge clk) begin
		int e;
		int b;
		if (!rst_n) begin
			cyc = 0;
			faults = 0;
			rowUp = '0;
			for (int k = 0; k < BANKS; k++) begin
				tOpen[k] = -99;
				tClose[k] = -99;
				tRd[k] = -99;
				tWr[k] = -99;
			end
		end else begin
			cyc++;
			if (requestBus.valid) begin
				e = cyc + int'(requestBus.delay);
				b = int'(requestBus.bank);
				case (requestBus.cmd)
				CMD_ROW_OPEN: begin
					if (rowUp[b])
						faults++;
					gap(e - tClose[b], RP_CYC);
					gap(e - tRd[b], RDP_CYC + RP_CYC);
					gap(e - tWr[b], WDP_CYC + RP_CYC);
					for (int k = 0; k < BANKS; k++)
						gap(e - tOpen[k], (k == b) ? RC_CYC : RR_CYC);
					tOpen[b] = e;
					rowUp[b] = 1'b1;
				end
				CMD_READ: begin
					if (!rowUp[b])
						faults++;
					gap(e - tOpen[b], RCDR_CYC);
					gap(e - tClose[b], RP_CYC + RCDR_CYC);
					for (int k = 0; k < BANKS; k++) begin
						gap(e - tRd[k], CC_CYC);
						gap(e - tWr[k], WR_CYC);
					end
					tRd[b] = e;
				end
				CMD_WRITE: begin
					if (!rowUp[b])
						faults++;
					gap(e - tOpen[b], RCDW_CYC);
					gap(e - tClose[b], RP_CYC + RCDW_CYC);
					for (int k = 0; k < BANKS; k++) begin
						gap(e - tWr[k], CC_CYC);
						gap(e - tRd[k], RW_CYC);
					end
					tWr[b] = e;
				end
				CMD_ROW_CLOSE: begin
					if (!rowUp[b])
						faults++;
					gap(e - tRd[b], RDP_CYC);
					gap(e - tWr[b], WDP_CYC);
					gap(e - tOpen[b], RAS_CYC);
					for (int k = 0; k < BANKS; k++)
						gap(e - tClose[k], (k == b) ? RC_CYC : PP_CYC);
					tClose[b] = e;
					rowUp[b] = 1'b0;
				end
				// Unknown command on the bus
				default: faults++;
				endcase
			end
		end
	end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the request spacing scheduler
module testbench
	import drsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk; // Request clock
	logic rst_n; // Reset, active low
	logic reqValid; // Request strobe
	logic reqReady; // Scheduler idle
	drsr_req_s req; // Request fields
	logic doneStb; // Request finished
	logic busy; // Scheduler working
	drsr_pkt_s requestBus; // Bus packet
	logic [BANKS-1:0] bankOpen; // Open banks
	int faults; // Model spacing faults
	int errTotal; // Mismatches
	int nChecks; // Comparisons
	int seed; // Random seed
	int sent; // Requests taken
	int gotDone; // Done pulses seen
	logic [BANKS-1:0] upB; // Expected open banks
	logic [ROW_W-1:0] rowB[BANKS]; // Expected open rows
	logic [31:0] expQ[$]; // Expected packet keys

	drsr_sched i_drsr_sched (
		.clk(clk),
		.rst_n(rst_n),
		.reqValid(reqValid),
		.reqReady(reqReady),
		.req(req),
		.doneStb(doneStb),
		.busy(busy),
		.requestBus(requestBus),
		.bankOpen(bankOpen)
	);

	drsr_dram_model i_drsr_dram_model (
		.clk(clk),
		.rst_n(rst_n),
		.requestBus(requestBus),
		.faults(faults)
	);

	// ****
	// Helpers
	// ****
	// Fields that matter for each command
	function automatic logic [31:0] key(input drsr_cmd_e c, input logic [BANK_W-1:0] b,
		input logic [ROW_W-1:0] r, input logic [COL_W-1:0] cl, input logic [DEL_W-1:0] d);
		logic colCmd;
		colCmd = (c == CMD_READ) || (c == CMD_WRITE);
		return {6'h0, c, b, d, (c == CMD_ROW_OPEN) ? r : 12'h0, colCmd ? cl : 6'h0};
	endfunction

	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Print verdict and stop
	task automatic wrapUp();
		if (errTotal == 0 && nChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Note packets a request must produce
	task automatic plan(input drsr_req_s r);
		drsr_cmd_e c;
		c = (r.op == OP_WRITE) ? CMD_WRITE : CMD_READ;
		if (r.op == OP_CLOSE) begin
			if (upB[r.bank])
				expQ.push_back(key(CMD_ROW_CLOSE, r.bank, 0, 0, 0));
			upB[r.bank] = 1'b0;
		end else begin
			if (upB[r.bank] && rowB[r.bank] != r.row)
				expQ.push_back(key(CMD_ROW_CLOSE, r.bank, 0, 0, 0));
			if (!upB[r.bank] || rowB[r.bank] != r.row)
				expQ.push_back(key(CMD_ROW_OPEN, r.bank, r.row, 0, 0));
			expQ.push_back(key(c, r.bank, 0, r.col, r.delay));
			upB[r.bank] = 1'b1;
			rowB[r.bank] = r.row;
		end
	endtask

	// Offer one request once the scheduler is ready
	task automatic send(input drsr_req_s r);
		int n;
		n = 0;
		@(posedge clk);
		#10;
		while (!reqReady && n < 100) begin
			@(posedge clk);
			#10;
			n++;
		end
		if (n == 100) begin
			errTotal++;
			wrapUp();
		end
		reqValid = 1'b1;
		req = r;
		plan(r);
		sent++;
		@(posedge clk);
		#10;
		reqValid = 1'b0;
	endtask

	// ****
	// Clock, watchdog, monitor
	// ****
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Cut a hang short
	initial begin
		repeat (100000) @(posedge clk);
		errTotal++;
		wrapUp();
	end

	// Match each bus packet with the oldest note
	always @(posedge clk) begin
		if (rst_n === 1'b1 && doneStb === 1'b1)
			gotDone++;
		if (rst_n === 1'b1 && requestBus.valid !== 1'b0)
			check(key(requestBus.cmd, requestBus.bank, requestBus.row, requestBus.col,
				requestBus.delay), (expQ.size() != 0) ? expQ.pop_front() : 32'h0);
	end

	// ****
	// Main sequence
	// ****
	initial begin
		drsr_req_s r;
		int n;
		rst_n = 1'b0;
		reqValid = 1'b0;
		req = '0;
		errTotal = 0;
		nChecks = 0;
		seed = 94;
		sent = 0;
		gotDone = 0;
		upB = '0;
		repeat (20) @(posedge clk);
		#10;
		rst_n = 1'b1;
		// Random mix over few rows for hits, misses and empties
		for (int i = 0; i < 300; i++) begin
			r.op = drsr_op_e'({$random(seed)} % 3);
			r.bank = 3'($random(seed));
			r.row = 12'({$random(seed)} % 2);
			r.col = 6'($random(seed));
			r.delay = 2'($random(seed));
			send(r);
		end
		n = 0;
		while ((busy !== 1'b0 || expQ.size() != 0) && n < 200) begin
			@(posedge clk);
			n++;
		end
		// Drain limit used up counts as a mismatch
		if (n == 200) begin
			errTotal++;
		end
		repeat (3) @(posedge clk);
		check(32'(expQ.size()), 32'h0);
		check(32'(gotDone), 32'(sent));
		check(32'(bankOpen), 32'(upB));
		check(32'(faults), 32'h0);
		wrapUp();
	end
endmodule
